//--- srh_defs.svh
// timing and width constants for the asynchronous static memory host
`ifndef SRH_DEFS_SVH
`define SRH_DEFS_SVH

`define SRH_ADDR_W 13
`define SRH_DATA_W 8
`define SRH_SYNC_STAGES 2

`define SRH_CLK_NS 25
`define SRH_T_WC_NS 15
`define SRH_T_WP_NS 10
`define SRH_T_AA_NS 15
`define SRH_T_HZ_NS 7
`define SRH_T_RC_NS 15

`define SRH_CYC(ns) (((ns) + `SRH_CLK_NS - 1) / `SRH_CLK_NS)
`define SRH_WP_CYC `SRH_CYC(`SRH_T_WP_NS)
`define SRH_AA_CYC `SRH_CYC(`SRH_T_AA_NS)
`define SRH_HZ_CYC `SRH_CYC(`SRH_T_HZ_NS)
`define SRH_RC_CYC `SRH_CYC(`SRH_T_RC_NS)
`define SRH_RD_HOLD_CYC (`SRH_AA_CYC + `SRH_SYNC_STAGES)

`endif

//--- srh_pkg.sv
// types shared by the memory host and its pin synchroniser
`include "srh_defs.svh"
`default_nettype none
package srh_pkg;
    typedef logic [`SRH_ADDR_W-1:0] srh_addr_type;
    typedef logic [`SRH_DATA_W-1:0] srh_data_type;

    typedef enum logic [7:0] {
        SRH_IDLE = 8'h01,
        SRH_WSET = 8'h02,
        SRH_WPUL = 8'h04,
        SRH_WEND = 8'h08,
        SRH_RACC = 8'h10,
        SRH_TURN = 8'h20,
        SRH_RET = 8'h40,
        SRH_RREC = 8'h80
    } srh_state_type;

    typedef struct packed {
        srh_data_type d1;
        srh_data_type d2;
        logic s1;
        logic s2;
    } srh_sync_type;

    typedef struct packed {
        srh_state_type st;
        logic [3:0] cnt;
        srh_addr_type addr;
        srh_data_type dout;
        logic doe;
        logic csN;
        logic csHi;
        logic weN;
        logic oeN;
        logic ready;
        logic rspValid;
        srh_data_type rspData;
        logic ret;
    } srh_host_type;
endpackage
`default_nettype wire

//--- srh_sync_if.sv
// raw pin levels in, synchronised levels out
`default_nettype none
interface srh_sync_if;
    import srh_pkg::*;
    srh_data_type dataRaw;
    logic supplyRaw;
    srh_data_type dataSync;
    logic supplyOkSync;
    modport syncer (input dataRaw, input supplyRaw, output dataSync, output supplyOkSync);
    modport user (output dataRaw, output supplyRaw, input dataSync, input supplyOkSync);
endinterface
`default_nettype wire

//--- srh_pin_sync.sv
// two-flop synchroniser for data pins and supply-good level
`include "srh_defs.svh"
`default_nettype none
module srh_pin_sync (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    srh_sync_if.syncer sif
);
    import srh_pkg::*;
    srh_sync_type q_r;
    srh_sync_type q_nxt;

    // first stage feeds only the second stage
    always_comb begin
        q_nxt = q_r;
        if (ce) begin
            q_nxt.d1 = sif.dataRaw;
            q_nxt.d2 = q_r.d1;
            q_nxt.s1 = sif.supplyRaw;
            q_nxt.s2 = q_r.s1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign sif.dataSync = q_r.d2;
    assign sif.supplyOkSync = q_r.s2;
endmodule
`default_nettype wire

//--- srh_sram_host.sv
// synchronous host driving an 8k x 8 asynchronous static memory
`include "srh_defs.svh"
`default_nettype none
module srh_sram_host (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire srh_pkg::srh_addr_type reqAddr,
    input wire srh_pkg::srh_data_type reqWdata,
    output logic reqReady,
    output logic rspValid,
    output srh_pkg::srh_data_type rspData,
    input wire logic retReq,
    input wire logic supplyOk,
    output logic retActive,
    output srh_pkg::srh_addr_type addr_lines,
    output logic chip_select_n,
    output logic chip_select_hi,
    output logic write_strobe_n,
    output logic output_gate_n,
    input wire srh_pkg::srh_data_type data_lines_in,
    output srh_pkg::srh_data_type data_lines_out,
    output logic data_lines_oe
);
    import srh_pkg::*;

    localparam logic [3:0] WpCnt = 4'(`SRH_WP_CYC - 1);
    localparam logic [3:0] RdCnt = 4'(`SRH_RD_HOLD_CYC - 1);
    localparam logic [3:0] HzCnt = 4'(`SRH_HZ_CYC - 1);
    localparam logic [3:0] RcCnt = 4'(`SRH_RC_CYC - 1);

    srh_sync_if sif ();
    assign sif.dataRaw = data_lines_in;
    assign sif.supplyRaw = supplyOk;

    srh_pin_sync u_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ce(ce),
        .sif(sif)
    );

    srh_host_type q_r;
    srh_host_type q_nxt;

    always_comb begin
        q_nxt = q_r;
        q_nxt.rspValid = 1'b0;
        if (!ce) begin
            q_nxt = q_r;
        end else begin
            case (q_r.st)
                SRH_IDLE: begin
                    if (reqValid && q_r.ready) begin
                        // address set with select, strobes registered
                        q_nxt.ready = 1'b0;
                        q_nxt.addr = reqAddr;
                        q_nxt.csN = 1'b0;
                        q_nxt.csHi = 1'b1;
                        if (reqWrite) begin
                            // gate already high a cycle or more, so bus is ours
                            q_nxt.dout = reqWdata;
                            q_nxt.doe = 1'b1;
                            q_nxt.st = SRH_WSET;
                        end else begin
                            q_nxt.oeN = 1'b0; // gate opened only with strobe high
                            q_nxt.cnt = RdCnt;
                            q_nxt.st = SRH_RACC;
                        end
                    end else if (retReq) begin
                        // memory already deselected here
                        q_nxt.ready = 1'b0;
                        q_nxt.ret = 1'b1;
                        q_nxt.st = SRH_RET;
                    end
                end
                SRH_WSET: begin
                    // select a cycle ahead of strobe keeps memory pins released
                    q_nxt.weN = 1'b0;
                    q_nxt.cnt = WpCnt; // strobe low rounded up to whole cycles
                    q_nxt.st = SRH_WPUL;
                end
                SRH_WPUL: begin
                    if (q_r.cnt == 4'h0) begin
                        q_nxt.weN = 1'b1;
                        q_nxt.st = SRH_WEND;
                    end else begin
                        q_nxt.cnt = q_r.cnt - 4'h1;
                    end
                end
                SRH_WEND: begin
                    // data and address held one cycle past strobe rise
                    q_nxt.csN = 1'b1;
                    q_nxt.csHi = 1'b0;
                    q_nxt.doe = 1'b0;
                    q_nxt.ready = 1'b1;
                    q_nxt.st = SRH_IDLE;
                end
                SRH_RACC: begin
                    // strobes held through access time plus the two sync stages
                    if (q_r.cnt == 4'h0) begin
                        q_nxt.rspData = sif.dataSync;
                        q_nxt.rspValid = 1'b1;
                        q_nxt.oeN = 1'b1;
                        q_nxt.csN = 1'b1;
                        q_nxt.csHi = 1'b0;
                        q_nxt.cnt = HzCnt;
                        q_nxt.st = SRH_TURN;
                    end else begin
                        q_nxt.cnt = q_r.cnt - 4'h1;
                    end
                end
                SRH_TURN: begin
                    // wait out memory turn-off before any write may drive
                    if (q_r.cnt == 4'h0) begin
                        q_nxt.ready = 1'b1;
                        q_nxt.st = SRH_IDLE;
                    end else begin
                        q_nxt.cnt = q_r.cnt - 4'h1;
                    end
                end
                SRH_RET: begin
                    if (!retReq && sif.supplyOkSync) begin
                        q_nxt.cnt = RcCnt;
                        q_nxt.st = SRH_RREC;
                    end
                end
                SRH_RREC: begin
                    // one read cycle of recovery after supply returns
                    if (q_r.cnt == 4'h0) begin
                        q_nxt.ret = 1'b0;
                        q_nxt.ready = 1'b1;
                        q_nxt.st = SRH_IDLE;
                    end else begin
                        q_nxt.cnt = q_r.cnt - 4'h1;
                    end
                end
                default: begin
                    // recover fully, else a stray state could leave requests blocked for good
                    q_nxt.st = SRH_IDLE;
                    q_nxt.ready = 1'b1;
                    q_nxt.ret = 1'b0;
                    q_nxt.csN = 1'b1;
                    q_nxt.csHi = 1'b0;
                    q_nxt.weN = 1'b1;
                    q_nxt.oeN = 1'b1;
                    q_nxt.doe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            q_r <= '{st: SRH_IDLE, cnt: 4'h0, addr: '0, dout: '0, doe: 1'b0, csN: 1'b1, csHi: 1'b0,
                     weN: 1'b1, oeN: 1'b1, ready: 1'b1, rspValid: 1'b0, rspData: '0, ret: 1'b0};
        end else begin
            q_r <= q_nxt;
        end
    end

    assign reqReady = q_r.ready;
    assign rspValid = q_r.rspValid;
    assign rspData = q_r.rspData;
    assign retActive = q_r.ret;
    assign addr_lines = q_r.addr;
    assign chip_select_n = q_r.csN;
    assign chip_select_hi = q_r.csHi;
    assign write_strobe_n = q_r.weN;
    assign output_gate_n = q_r.oeN;
    assign data_lines_out = q_r.dout;
    assign data_lines_oe = q_r.doe;

    default clocking cb @(posedge ref_clk iff ce); endclocking
    default disable iff (!rst_b);

    addr_during_write_a: assert property (
        $changed(q_r.addr) |-> $past(q_r.weN) && q_r.weN)
        else $error("address moved during active write");

    read_write_excl_a: assert property (
        !(!q_r.weN && !q_r.oeN) && !(q_r.ret && !q_r.csN))
        else $error("conflicting strobe decode");

    addr_with_select_a: assert property (
        !q_r.oeN && $past(!q_r.oeN) |-> $stable(q_r.addr))
        else $error("address changed while reading");

    write_shape_a: assert property (
        $fell(q_r.weN) |=> $rose(q_r.weN) ##1 (q_r.csN && !q_r.csHi && !q_r.doe))
        else $error("write cycle sequence wrong");

    select_before_strobe_a: assert property (
        $fell(q_r.weN) |-> $past(!q_r.csN && q_r.csHi && q_r.doe))
        else $error("select not ahead of write strobe");

    write_data_hold_a: assert property (
        !q_r.weN |=> q_r.doe && $stable(q_r.dout))
        else $error("write data not held");

    no_contention_a: assert property (
        q_r.doe |-> q_r.oeN && $past(q_r.oeN, 2))
        else $error("bus driven while memory may drive");

    read_hold_a: assert property (
        $fell(q_r.oeN) |-> (!q_r.oeN && !q_r.csN) [*3] ##1 (q_r.oeN && q_r.rspValid))
        else $error("read strobe length wrong");

    retention_exit_a: assert property (
        $fell(q_r.ret) |-> $past(q_r.st == SRH_RREC) && q_r.csN && q_r.weN)
        else $error("retention left without recovery");
endmodule
`default_nettype wire

//--- srh_mem_model.sv
// behavioural 8k x 8 asynchronous static memory seen by the host
`default_nettype none
module srh_mem_model (
    input wire srh_pkg::srh_addr_type addr_lines,
    input wire logic chip_select_n,
    input wire logic chip_select_hi,
    input wire logic write_strobe_n,
    input wire logic output_gate_n,
    input wire logic supplyOk,
    input wire srh_pkg::srh_data_type hostData,
    input wire logic hostOe,
    output srh_pkg::srh_data_type busLevel,
    output logic [31:0] faults
);
    timeunit 1ns;
    timeprecision 100ps;
    import srh_pkg::*;
    srh_data_type store [0:8191];
    srh_data_type memData = 8'h00;
    srh_data_type lastLevel = 8'h00;
    logic memDrive = 1'b0;
    realtime fallT = 0.0;
    realtime dataT = 0.0;
    realtime selT = 0.0;
    wire logic sel = !chip_select_n && chip_select_hi;
    initial faults = 0;
    // 4 ns on and off: slowest legal turn-on, inside access and turn-off limits
    always @(sel or write_strobe_n or output_gate_n or addr_lines) begin
        memDrive <= #4 sel && write_strobe_n && !output_gate_n;
        memData <= #4 store[addr_lines];
    end
    // released bus shows the inverse so a stale sample cannot pass
    always @* busLevel = hostOe ? hostData : (memDrive ? memData : ~lastLevel);
    always @(hostData or hostOe or memData or memDrive) begin
        if (hostOe || memDrive)
            lastLevel = hostOe ? hostData : memData;
    end
    always @(negedge write_strobe_n) fallT = $realtime;
    always @(hostData or hostOe) dataT = $realtime;
    always @(posedge sel) selT = $realtime;
    always @(posedge write_strobe_n) begin
        if (sel) begin
            if ($realtime - fallT < 10.0 || $realtime - dataT < 8.0 || $realtime - selT < 12.0)
                faults++;
            store[addr_lines] = busLevel;
        end
    end
    always @(addr_lines) begin
        if (sel && !write_strobe_n)
            faults++;
    end
    always @(sel or supplyOk) begin
        if (sel && !supplyOk)
            faults++;
    end
    always @(hostOe or memDrive) begin
        if (hostOe && memDrive)
            faults++;
    end
endmodule
`default_nettype wire

//--- tb_srh_sram_host.sv
// self-checking bench for the static memory host
`default_nettype none
`define CHK(nm, exp, got) begin samplesChecked++; if ((got) !== (exp)) begin errTotal++; \
    $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module tb_srh_sram_host;
    timeunit 1ns;
    timeprecision 100ps;
    import srh_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic reqValid = 1'b0;
    logic reqWrite = 1'b0;
    logic retReq = 1'b0;
    logic supplyOk = 1'b1;
    srh_addr_type reqAddr = 13'h0000;
    srh_data_type reqWdata = 8'h00;
    logic reqReady, rspValid, retActive, chip_select_n, chip_select_hi, write_strobe_n, output_gate_n, data_lines_oe;
    srh_data_type rspData, data_lines_out, busLevel;
    srh_addr_type addr_lines;
    logic [31:0] faults;
    int errTotal = 0;
    int samplesChecked = 0;
    srh_addr_type ta [4] = '{13'h0000, 13'h1fff, 13'h0aaa, 13'h1555};
    srh_data_type td [4] = '{8'h5a, 8'ha5, 8'hff, 8'h00};

    always #12.5 ref_clk = ~ref_clk;

    srh_sram_host dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .reqValid(reqValid), .reqWrite(reqWrite),
        .reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
        .retReq(retReq), .supplyOk(supplyOk), .retActive(retActive), .addr_lines(addr_lines),
        .chip_select_n(chip_select_n), .chip_select_hi(chip_select_hi), .write_strobe_n(write_strobe_n),
        .output_gate_n(output_gate_n), .data_lines_in(busLevel), .data_lines_out(data_lines_out),
        .data_lines_oe(data_lines_oe));
    srh_mem_model memModel (.addr_lines(addr_lines), .chip_select_n(chip_select_n), .chip_select_hi(chip_select_hi),
        .write_strobe_n(write_strobe_n), .output_gate_n(output_gate_n), .supplyOk(supplyOk),
        .hostData(data_lines_out), .hostOe(data_lines_oe), .busLevel(busLevel), .faults(faults));

    task automatic doWrite(input srh_addr_type a, input srh_data_type d);
        reqValid = 1'b1;
        reqWrite = 1'b1;
        reqAddr = a;
        reqWdata = d;
        @(negedge ref_clk);
        reqValid = 1'b0;
        `CHK("wsel", {a, d}, {addr_lines, data_lines_out})
        `CHK("wpins", 4'h6, {chip_select_n, chip_select_hi, data_lines_oe, reqReady})
        @(negedge ref_clk);
        `CHK("strobe", 2'b01, {write_strobe_n, output_gate_n})
        repeat (2) @(negedge ref_clk);
        `CHK("wend", 5'b11001, {write_strobe_n, chip_select_n, chip_select_hi, data_lines_oe, reqReady})
    endtask

    task automatic doRead(input srh_addr_type a, input srh_data_type e);
        reqValid = 1'b1;
        reqWrite = 1'b0;
        reqAddr = a;
        @(negedge ref_clk);
        reqValid = 1'b0;
        `CHK("raddr", a, addr_lines)
        `CHK("rsel", 5'h0a, {chip_select_n, chip_select_hi, output_gate_n, write_strobe_n, reqReady})
        repeat (3) @(negedge ref_clk);
        `CHK("rdata", {3'b111, e}, {rspValid, output_gate_n, chip_select_n, rspData})
        @(negedge ref_clk);
        `CHK("rend", 2'b01, {rspValid, reqReady})
    endtask

    task automatic testReset();
        `CHK("idle", 3'h4, {reqReady, rspValid, retActive})
        `CHK("idle pins", 5'h16, {chip_select_n, chip_select_hi, write_strobe_n, output_gate_n, data_lines_oe})
        $display("test reset done");
    endtask

    task automatic testData();
        for (int i = 0; i < 4; i++)
            doWrite(ta[i], td[i]);
        for (int i = 0; i < 4; i++)
            doRead(ta[i], td[i]);
        doWrite(13'h1fff, 8'h3c);
        doRead(13'h1fff, 8'h3c);
        doRead(13'h0000, 8'h5a);
        $display("test data done");
    endtask

    task automatic testFreeze();
        reqValid = 1'b1;
        reqWrite = 1'b1;
        reqAddr = 13'h0100;
        reqWdata = 8'h77;
        @(negedge ref_clk);
        reqValid = 1'b0;
        ce = 1'b0;
        repeat (3) @(negedge ref_clk);
        `CHK("frozen", 3'b010, {chip_select_n, write_strobe_n, reqReady})
        ce = 1'b1;
        repeat (3) @(negedge ref_clk);
        `CHK("thaw", 1'b1, reqReady)
        doRead(13'h0100, 8'h77);
        $display("test freeze done");
    endtask

    task automatic testRetain();
        int n;
        retReq = 1'b1;
        doRead(13'h0aaa, 8'hff);
        @(negedge ref_clk);
        `CHK("retain", 3'b110, {retActive, chip_select_n, reqReady})
        supplyOk = 1'b0;
        reqValid = 1'b1;
        reqWrite = 1'b1;
        reqWdata = 8'h00;
        repeat (4) @(negedge ref_clk);
        `CHK("refused", 2'b10, {chip_select_n, reqReady})
        reqValid = 1'b0;
        retReq = 1'b0;
        supplyOk = 1'b1;
        n = 0;
        while (retActive !== 1'b0 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK("recovery", 1'b1, n >= 4 && n <= 5)
        doRead(13'h0aaa, 8'hff);
        $display("test retain done");
    endtask

    task automatic wrapUp();
        `CHK("partner faults", 32'h0, faults)
        $display("compares %0d mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (12) @(negedge ref_clk);
        rst_b = 1'b1;
        @(negedge ref_clk);
        testReset();
        testData();
        testFreeze();
        testRetain();
        wrapUp();
    end

    // the whole run needs well under 200 cycles
    initial begin
        #(25 * 2000);
        errTotal++;
        $display("watchdog expired");
        wrapUp();
    end
endmodule
`default_nettype wire
